// ===== design/bit_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-stage synchroniser; the first stage feeds only the second
module bit_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset_n,
	// data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= '0;
			q      <= '0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule

`default_nettype wire

// ===== design/phy_pins_pkg.sv
package phy_pins_pkg;

	// register indices; the bus byte address is four times the index
	localparam logic [4:0] REG_CTRL_IDX   = 5'h00;
	localparam logic [4:0] REG_VCTRL_IDX  = 5'h1E;
	localparam logic [4:0] REG_STATUS_IDX = 5'h1F;
	localparam int         WB_ADDR_W      = 7;

	// control register fields
	localparam int CTRL_SPEED_BIT = 13;
	localparam int VCTRL_MODE_HI  = 15;
	localparam int VCTRL_MODE_LO  = 14;

	// status register fields
	localparam int STAT_ADDR_LSB = 0;
	localparam int STAT_CFG_LSB  = 8;
	localparam int STAT_DONE_BIT = 16;
	localparam int STAT_LINK_BIT = 17;
	localparam int STAT_ACT_BIT  = 18;

	// reset values
	localparam logic       SPEED_RESET    = 1'h1;
	localparam logic [1:0] IND_MODE_RESET = 2'h0;
	localparam logic [1:0] ADDR_UPPER     = 2'h0;
	localparam logic [2:0] ADDR_STRAP_RST = 3'h1;
	localparam logic [2:0] CFG_STRAP_RST  = 3'h0;

	// indicator modes
	localparam logic [1:0] IND_SPEED_LINK = 2'h0;
	localparam logic [1:0] IND_ACTIVITY   = 2'h1;

	// data interface configuration codes
	localparam logic [2:0] CFG_MII  = 3'h0;
	localparam logic [2:0] CFG_RMII = 3'h1;
	localparam logic [2:0] CFG_LOOP = 3'h4;

	typedef enum logic [1:0] {PATH_IDLE, PATH_MII, PATH_RMII, PATH_LOOP} path_t;
	typedef enum logic [1:0] {STRAP_SETTLE, STRAP_LATCH, STRAP_DONE} strap_state_t;

	// timing
	localparam int CLK_HZ           = 20_000_000;
	localparam int STRAP_SETTLE_CYC = 2;
	localparam int ACT_HOLD_MS      = 50;
	localparam int BLINK_HALF_MS    = 100;

endpackage

// ===== design/phy_strap_led_and_data_pins.sv
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// - second indicator: mode 00 high at 10M, low at 100M; mode 01 low on activity
// - indicator mode comes from vendor control register bits 15 to 14
// - second indicator pin level at reset is stored as speed select bit 13
// - strap pins stay inputs during reset, driven as outputs only afterwards
// - MII receive nibble follows receive clock, valid only while receive valid is high
// - RMII delivers two receive bits each reference period while carrier/valid is high
// - MII transmit nibble taken with transmit enable, ignored while it is low
// - RMII captures two transmit bits each reference period while enable is high
// - three address straps latched at reset, default pulls give address 00001
// - upper two bits of the management address are always zero
// - three configuration straps latched at reset, code 000 selects MII
module phy_strap_led_and_data_pins #(
	parameter int ACT_HOLD_CYC   = phy_pins_pkg::ACT_HOLD_MS * (phy_pins_pkg::CLK_HZ / 1000),
	parameter int BLINK_HALF_CYC = phy_pins_pkg::BLINK_HALF_MS * (phy_pins_pkg::CLK_HZ / 1000)
) (
	// system clock and chip reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [6:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// indicator pins, released during reset; only the speed one is a strap input
	input  wire logic        speed_activity_indicator_in,
	output logic             speed_activity_indicator_out,
	output logic             speed_activity_indicator_oe,
	input  wire logic        link_activity_indicator_in,
	output logic             link_activity_indicator_out,
	output logic             link_activity_indicator_oe,
	// address and configuration strap pins
	input  wire logic        mgmt_addr_strap_hi_in,
	input  wire logic        mgmt_addr_strap_mid_in,
	input  wire logic        mgmt_addr_strap_lo_in,
	output logic      [2:0]  mgmt_addr_strap_out,
	output logic      [2:0]  mgmt_addr_strap_oe,
	input  wire logic [2:0]  cfg_strap_in,
	output logic      [2:0]  cfg_strap_out,
	output logic      [2:0]  cfg_strap_oe,
	// latched configuration and line status
	input  wire logic        link_up,
	output logic      [4:0]  mgmt_addr,
	output logic      [2:0]  iface_cfg,
	// link side, on the data interface clock
	input  wire logic        link_clk,
	input  wire logic [3:0]  rx_line_data,
	input  wire logic        rx_line_valid,
	output logic      [3:0]  rxd,
	output logic             rx_dv,
	input  wire logic [3:0]  txd,
	input  wire logic        tx_en,
	output logic      [3:0]  tx_line_data,
	output logic             tx_line_valid
);

	localparam int ACT_W   = $clog2(ACT_HOLD_CYC + 1);
	localparam int BLINK_W = $clog2(BLINK_HALF_CYC + 1);
	localparam int SET_W   = $clog2(phy_pins_pkg::STRAP_SETTLE_CYC + 1);

	function automatic logic reg_hit(input logic [6:0] adr, input logic [4:0] idx);
		reg_hit = (adr == {idx, 2'h0});
	endfunction

	// ---------------- strap sampling ----------------
	logic [6:0] strap_pins;
	logic [6:0] strap_s;
	logic [SET_W-1:0] settle_cnt_r;
	phy_pins_pkg::strap_state_t strap_state_r;
	logic       strap_done_r;
	logic       speed_r;
	logic [2:0] addr_strap_r;
	logic [2:0] cfg_r;

	assign strap_pins = {speed_activity_indicator_in, mgmt_addr_strap_hi_in,
		mgmt_addr_strap_mid_in, mgmt_addr_strap_lo_in, cfg_strap_in};

	bit_sync #(.WIDTH(7)) strap_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (strap_pins),
		.q       (strap_s)
	);

	// wait until the synchroniser holds real pin levels before latching
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_state_r <= phy_pins_pkg::STRAP_SETTLE;
			settle_cnt_r  <= '0;
			strap_done_r  <= 1'b0;
			addr_strap_r  <= phy_pins_pkg::ADDR_STRAP_RST;
			cfg_r         <= phy_pins_pkg::CFG_STRAP_RST;
		end else begin
			case (strap_state_r)
				phy_pins_pkg::STRAP_SETTLE: begin
					settle_cnt_r <= settle_cnt_r + SET_W'(1);
					if (settle_cnt_r == SET_W'(phy_pins_pkg::STRAP_SETTLE_CYC - 1)) begin
						strap_state_r <= phy_pins_pkg::STRAP_LATCH;
					end
				end
				phy_pins_pkg::STRAP_LATCH: begin
					addr_strap_r  <= strap_s[5:3];
					cfg_r         <= strap_s[2:0];
					strap_done_r  <= 1'b1;
					strap_state_r <= phy_pins_pkg::STRAP_DONE;
				end
				phy_pins_pkg::STRAP_DONE: begin
					strap_state_r <= phy_pins_pkg::STRAP_DONE;
				end
				default: begin
					strap_state_r <= phy_pins_pkg::STRAP_SETTLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mgmt_addr <= {phy_pins_pkg::ADDR_UPPER, phy_pins_pkg::ADDR_STRAP_RST};
			iface_cfg <= phy_pins_pkg::CFG_STRAP_RST;
		end else begin
			mgmt_addr <= {phy_pins_pkg::ADDR_UPPER, addr_strap_r};
			iface_cfg <= cfg_r;
		end
	end

	// ---------------- wishbone registers ----------------
	logic       wb_req;
	logic       wb_wr;
	logic [1:0] ind_mode_r;
	logic [31:0] rd_nxt;
	logic       activity;

	assign wb_req = wb_cyc_i && wb_stb_i;
	assign wb_wr  = wb_req && wb_we_i && !wb_ack_o;

	// one wait state: ack in the cycle after the request is seen, then dropped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req && !wb_ack_o;
			wb_dat_o <= rd_nxt;
		end
	end

	// the strap value wins over a write landing in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			speed_r <= phy_pins_pkg::SPEED_RESET;
		end else if (strap_state_r == phy_pins_pkg::STRAP_LATCH) begin
			speed_r <= strap_s[6];
		end else if (wb_wr && wb_sel_i[1] && reg_hit(wb_adr_i, phy_pins_pkg::REG_CTRL_IDX)) begin
			speed_r <= wb_dat_i[phy_pins_pkg::CTRL_SPEED_BIT];
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ind_mode_r <= phy_pins_pkg::IND_MODE_RESET;
		end else if (wb_wr && wb_sel_i[1] && reg_hit(wb_adr_i, phy_pins_pkg::REG_VCTRL_IDX)) begin
			ind_mode_r <= wb_dat_i[phy_pins_pkg::VCTRL_MODE_HI:phy_pins_pkg::VCTRL_MODE_LO];
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (reg_hit(wb_adr_i, phy_pins_pkg::REG_CTRL_IDX)) begin
			rd_nxt[phy_pins_pkg::CTRL_SPEED_BIT] = speed_r;
		end else if (reg_hit(wb_adr_i, phy_pins_pkg::REG_VCTRL_IDX)) begin
			rd_nxt[phy_pins_pkg::VCTRL_MODE_HI:phy_pins_pkg::VCTRL_MODE_LO] = ind_mode_r;
		end else if (reg_hit(wb_adr_i, phy_pins_pkg::REG_STATUS_IDX)) begin
			rd_nxt[phy_pins_pkg::STAT_ADDR_LSB +: 5] = {phy_pins_pkg::ADDR_UPPER, addr_strap_r};
			rd_nxt[phy_pins_pkg::STAT_CFG_LSB +: 3]  = cfg_r;
			rd_nxt[phy_pins_pkg::STAT_DONE_BIT]      = strap_done_r;
			rd_nxt[phy_pins_pkg::STAT_LINK_BIT]      = link_up;
			rd_nxt[phy_pins_pkg::STAT_ACT_BIT]       = activity;
		end
	end

	// ---------------- activity from the link domain ----------------
	logic act_tog_s;
	logic act_prev_r;
	logic act_tog_r;
	logic [ACT_W-1:0] act_cnt_r;
	logic [BLINK_W-1:0] blink_cnt_r;
	logic blink_r;

	bit_sync #(.WIDTH(1)) act_sync (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (act_tog_r),
		.q       (act_tog_s)
	);

	// stretch each burst so the indicator is visible to the eye
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			act_prev_r <= 1'b0;
			act_cnt_r  <= '0;
		end else begin
			act_prev_r <= act_tog_s;
			if (act_tog_s != act_prev_r) begin
				act_cnt_r <= ACT_W'(ACT_HOLD_CYC - 1);
			end else if (act_cnt_r != '0) begin
				act_cnt_r <= act_cnt_r - ACT_W'(1);
			end
		end
	end

	assign activity = (act_cnt_r != '0);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			blink_cnt_r <= '0;
			blink_r     <= 1'b0;
		end else if (blink_cnt_r == '0) begin
			blink_cnt_r <= BLINK_W'(BLINK_HALF_CYC - 1);
			blink_r     <= !blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r - BLINK_W'(1);
		end
	end

	// ---------------- indicator and strap pin drivers ----------------
	logic pins_oe_r;

	// pins stay released while straps settle; reserved modes leave indicators off
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pins_oe_r                    <= 1'b0;
			speed_activity_indicator_out <= 1'b1;
			link_activity_indicator_out  <= 1'b1;
		end else begin
			pins_oe_r <= strap_done_r;
			case (ind_mode_r)
				phy_pins_pkg::IND_SPEED_LINK: begin
					speed_activity_indicator_out <= !speed_r;
					link_activity_indicator_out  <= !link_up || (activity && blink_r);
				end
				phy_pins_pkg::IND_ACTIVITY: begin
					speed_activity_indicator_out <= !activity;
					link_activity_indicator_out  <= !link_up;
				end
				default: begin
					speed_activity_indicator_out <= 1'b1;
					link_activity_indicator_out  <= 1'b1;
				end
			endcase
		end
	end

	assign speed_activity_indicator_oe = pins_oe_r;
	assign link_activity_indicator_oe  = pins_oe_r;
	assign mgmt_addr_strap_oe          = {3{pins_oe_r}};
	assign cfg_strap_oe                = {3{pins_oe_r}};

	// their run-time functions live elsewhere; here they idle low
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mgmt_addr_strap_out <= 3'h0;
			cfg_strap_out       <= 3'h0;
		end else begin
			mgmt_addr_strap_out <= 3'h0;
			cfg_strap_out       <= 3'h0;
		end
	end

	// ---------------- link domain data path ----------------
	logic link_rst_n;
	logic [3:0] cfg_l;
	phy_pins_pkg::path_t path;

	bit_sync #(.WIDTH(1)) link_rst_sync (
		.clk     (link_clk),
		.reset_n (reset_n),
		.d       (1'b1),
		.q       (link_rst_n)
	);

	// configuration is static once latched, so a plain level crossing suffices
	bit_sync #(.WIDTH(4)) cfg_sync (
		.clk     (link_clk),
		.reset_n (reset_n),
		.d       ({strap_done_r, cfg_r}),
		.q       (cfg_l)
	);

	always_comb begin
		path = phy_pins_pkg::PATH_IDLE;
		if (cfg_l[3]) begin
			case (cfg_l[2:0])
				phy_pins_pkg::CFG_MII:  path = phy_pins_pkg::PATH_MII;
				phy_pins_pkg::CFG_RMII: path = phy_pins_pkg::PATH_RMII;
				phy_pins_pkg::CFG_LOOP: path = phy_pins_pkg::PATH_LOOP;
				default:                path = phy_pins_pkg::PATH_IDLE;
			endcase
		end
	end

	// receive toward the mac; data is zeroed outside valid
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rxd   <= 4'h0;
			rx_dv <= 1'b0;
		end else begin
			case (path)
				phy_pins_pkg::PATH_MII: begin
					rx_dv <= rx_line_valid;
					rxd   <= rx_line_valid ? rx_line_data : 4'h0;
				end
				phy_pins_pkg::PATH_RMII: begin
					rx_dv <= rx_line_valid;
					rxd   <= rx_line_valid ? {2'h0, rx_line_data[1:0]} : 4'h0;
				end
				phy_pins_pkg::PATH_LOOP: begin
					rx_dv <= tx_en;
					rxd   <= tx_en ? txd : 4'h0;
				end
				default: begin
					rx_dv <= 1'b0;
					rxd   <= 4'h0;
				end
			endcase
		end
	end

	// transmit from the mac; loopback keeps the line quiet
	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_line_data  <= 4'h0;
			tx_line_valid <= 1'b0;
		end else begin
			case (path)
				phy_pins_pkg::PATH_MII: begin
					tx_line_valid <= tx_en;
					tx_line_data  <= tx_en ? txd : 4'h0;
				end
				phy_pins_pkg::PATH_RMII: begin
					tx_line_valid <= tx_en;
					tx_line_data  <= tx_en ? {2'h0, txd[1:0]} : 4'h0;
				end
				default: begin
					tx_line_valid <= 1'b0;
					tx_line_data  <= 4'h0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or negedge link_rst_n) begin
		if (!link_rst_n) begin
			act_tog_r <= 1'b0;
		end else if (path != phy_pins_pkg::PATH_IDLE && (tx_en || rx_line_valid)) begin
			act_tog_r <= !act_tog_r;
		end
	end

	// ---------------- assertions ----------------
	speed_led_a: assert property (@(posedge clk) disable iff (!reset_n)
		(ind_mode_r == phy_pins_pkg::IND_SPEED_LINK)
		|=> (speed_activity_indicator_out == !$past(speed_r)))
		else $error("speed indicator does not follow speed select");

	mode_write_a: assert property (@(posedge clk) disable iff (!reset_n)
		(wb_wr && wb_sel_i[1] && wb_adr_i == {phy_pins_pkg::REG_VCTRL_IDX, 2'h0})
		|=> (ind_mode_r == $past(wb_dat_i[15:14])))
		else $error("indicator mode not taken from write");

	speed_strap_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(strap_done_r) |-> (speed_r == $past(strap_s[6])))
		else $error("speed select not latched from pin");

	pin_release_a: assert property (@(posedge clk) disable iff (!reset_n)
		!strap_done_r |=> !speed_activity_indicator_oe && !cfg_strap_oe[0])
		else $error("strap pin driven before latching");

	mii_rx_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		(path == phy_pins_pkg::PATH_MII && !rx_line_valid) |=> (!rx_dv && rxd == 4'h0))
		else $error("receive data presented without valid");

	rmii_rx_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		(path == phy_pins_pkg::PATH_RMII && rx_line_valid)
		|=> (rx_dv && rxd[1:0] == $past(rx_line_data[1:0])))
		else $error("rmii receive dibit lost");

	mii_tx_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		(path == phy_pins_pkg::PATH_MII) |=> (tx_line_valid == $past(tx_en)
		&& (tx_line_valid || tx_line_data == 4'h0)))
		else $error("transmit data not gated by enable");

	rmii_tx_a: assert property (@(posedge link_clk) disable iff (!link_rst_n)
		(path == phy_pins_pkg::PATH_RMII && tx_en)
		|=> (tx_line_valid && tx_line_data[1:0] == $past(txd[1:0])))
		else $error("rmii transmit dibit not captured");

	addr_strap_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(strap_done_r) |-> (addr_strap_r == $past(strap_s[5:3])))
		else $error("address straps not latched");

	addr_upper_a: assert property (@(posedge clk) disable iff (!reset_n)
		mgmt_addr[4:3] == phy_pins_pkg::ADDR_UPPER)
		else $error("upper address bits not zero");

	cfg_strap_a: assert property (@(posedge clk) disable iff (!reset_n)
		$rose(strap_done_r) |-> (cfg_r == $past(strap_s[2:0])))
		else $error("configuration straps not latched");

	strap_time_a: assert property (@(posedge clk) disable iff (!reset_n)
		!strap_done_r |-> ##[1:4] strap_done_r)
		else $error("strap latch did not complete after reset");

endmodule

`default_nettype wire

// ===== test/mac_model.sv
`timescale 1ns/100ps
`default_nettype none

module mac_model (
	// link clock
	input  wire logic       link_clk,
	// receive from the device
	input  wire logic [3:0] rxd,
	input  wire logic       rx_dv,
	// transmit toward the device
	output logic      [3:0] txd,
	output logic            tx_en
);
	logic [3:0] rx_got;
	int         rx_cnt;

	initial begin
		txd = 4'h0;
		tx_en = 1'b0;
		rx_cnt = 0;
	end

	// receive data counts only while valid is high
	always @(posedge link_clk) begin
		if (rx_dv === 1'b1) begin
			rx_got <= rxd;
			rx_cnt <= rx_cnt + 1;
		end
	end

	// one unit per clock under enable; released data is inverted so it cannot look valid
	task automatic send(input logic [3:0] n, input int gap);
		@(posedge link_clk);
		txd <= n;
		tx_en <= 1'b1;
		@(posedge link_clk);
		tx_en <= 1'b0;
		txd <= ~n;
		repeat (gap) @(posedge link_clk);
	endtask
endmodule

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
	typedef struct {logic s; logic [2:0] a; logic [2:0] c; logic [4:0] er; logic [4:0] et;} row_t;
	logic        clk, reset_n, link_clk, link_up;
	logic        cyc, stb, we;
	logic [6:0]  adr;
	logic [31:0] dat, rd, q;
	logic        ack;
	logic        spd_s;
	logic [2:0]  adr_s, cfg_s, adr_pin, cfg_pin, adr_out, adr_oe, cfg_out, cfg_oe;
	logic        spd_out, spd_oe, lnk_out, lnk_oe;
	logic [4:0]  mgmt_addr;
	logic [2:0]  iface_cfg;
	logic [3:0]  rx_line_data, rxd, txd, tx_line_data, tx_got;
	logic        rx_line_valid, rx_dv, tx_en, tx_line_valid;
	int          error_cnt, compares, cycles, tx_cnt, r0, t0;
	row_t        rows [4];

	// pins read back their pull or strap level until the device drives them
	assign adr_pin = (adr_oe & adr_out) | (~adr_oe & adr_s);
	assign cfg_pin = (cfg_oe & cfg_out) | (~cfg_oe & cfg_s);

	phy_strap_led_and_data_pins #(.ACT_HOLD_CYC(20), .BLINK_HALF_CYC(10)) dut (
		.clk(clk), .reset_n(reset_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
		.speed_activity_indicator_in(spd_oe ? spd_out : spd_s),
		.speed_activity_indicator_out(spd_out), .speed_activity_indicator_oe(spd_oe),
		.link_activity_indicator_in(lnk_oe ? lnk_out : 1'b1),
		.link_activity_indicator_out(lnk_out), .link_activity_indicator_oe(lnk_oe),
		.mgmt_addr_strap_hi_in(adr_pin[2]), .mgmt_addr_strap_mid_in(adr_pin[1]),
		.mgmt_addr_strap_lo_in(adr_pin[0]), .mgmt_addr_strap_out(adr_out),
		.mgmt_addr_strap_oe(adr_oe), .cfg_strap_in(cfg_pin), .cfg_strap_out(cfg_out),
		.cfg_strap_oe(cfg_oe), .link_up(link_up), .mgmt_addr(mgmt_addr),
		.iface_cfg(iface_cfg), .link_clk(link_clk), .rx_line_data(rx_line_data),
		.rx_line_valid(rx_line_valid), .rxd(rxd), .rx_dv(rx_dv), .txd(txd),
		.tx_en(tx_en), .tx_line_data(tx_line_data), .tx_line_valid(tx_line_valid)
	);

	mac_model mac (.link_clk(link_clk), .rxd(rxd), .rx_dv(rx_dv), .txd(txd), .tx_en(tx_en));

	always #25 clk = ~clk;
	always #80 link_clk = ~link_clk;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// single classic cycle, held until ack is sampled high
	task automatic wb(input logic w, input logic [6:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rd;
		if (n >= 50) chk("wb ack", 1, 0);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rx_send(input logic [3:0] n);
		@(posedge link_clk);
		rx_line_data <= n;
		rx_line_valid <= 1'b1;
		@(posedge link_clk);
		rx_line_valid <= 1'b0;
		rx_line_data <= ~n;
	endtask

	// data toward the line must be zero whenever it is not qualified
	always @(posedge link_clk) begin
		if (tx_line_valid === 1'b1) begin
			tx_got <= tx_line_data;
			tx_cnt <= tx_cnt + 1;
		end else if (reset_n === 1'b1) begin
			chk("idle tx line", 0, {28'h0, tx_line_data});
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			finish_test();
		end
	end

	initial begin
		{clk, link_clk, reset_n, cyc, stb, we, rx_line_valid} = '0;
		{adr, dat, rx_line_data} = '0;
		{error_cnt, compares, cycles, tx_cnt} = '0;
		link_up = 1'b1;
		spd_s = 1'b1;
		adr_s = 3'h1;
		cfg_s = 3'h0;
		rows[0] = '{1'b1, 3'h2, 3'h2, 5'h00, 5'h00};
		rows[1] = '{1'b1, 3'h1, 3'h0, 5'h1B, 5'h16};
		rows[2] = '{1'b0, 3'h7, 3'h1, 5'h13, 5'h12};
		rows[3] = '{1'b1, 3'h5, 3'h4, 5'h16, 5'h00};
		foreach (rows[i]) begin
			@(posedge clk);
			reset_n <= 1'b0;
			spd_s <= rows[i].s;
			adr_s <= rows[i].a;
			cfg_s <= rows[i].c;
			repeat (6) @(posedge clk);
			chk("oe in reset", 0, {spd_oe, lnk_oe, adr_oe, cfg_oe});
			reset_n <= 1'b1;
			repeat (25) @(posedge clk);
			chk("oe after reset", 8'hFF, {spd_oe, lnk_oe, adr_oe, cfg_oe});
			chk("mgmt addr", {2'b00, rows[i].a}, mgmt_addr);
			chk("iface cfg", rows[i].c, iface_cfg);
			wb(1'b0, 7'h7C, 32'h0);
			chk("status", {15'h3, 5'h0, rows[i].c, 3'h0, 2'b00, rows[i].a}, q & 32'h3_071F);
			wb(1'b0, 7'h00, 32'h0);
			chk("speed select", rows[i].s, q[13]);
			chk("speed ind", !rows[i].s, spd_out);
			r0 = mac.rx_cnt;
			t0 = tx_cnt;
			fork
				rx_send(4'hB);
				mac.send(4'h6, 0);
			join
			repeat (4) @(posedge link_clk);
			chk("rx count", rows[i].er[4], mac.rx_cnt - r0);
			if (rows[i].er[4]) chk("rx data", rows[i].er[3:0], mac.rx_got);
			chk("tx count", rows[i].et[4], tx_cnt - t0);
			if (rows[i].et[4]) chk("tx data", rows[i].et[3:0], tx_got);
			$display("test strap row %0d done", i);
		end
		// loopback path is active from here on; activity drives the indicator in mode 01
		wb(1'b1, 7'h78, 32'h0000_4000);
		wb(1'b0, 7'h78, 32'h0);
		chk("mode readback", 2'h1, q[15:14]);
		repeat (40) @(posedge clk);
		chk("no activity", 1, spd_out);
		chk("link ind lit", 0, lnk_out);
		mac.send(4'h5, 0);
		repeat (8) @(posedge clk);
		chk("activity lit", 0, spd_out);
		repeat (40) @(posedge clk);
		chk("activity off", 1, spd_out);
		wb(1'b1, 7'h78, 32'h0000_8000);
		repeat (3) @(posedge clk);
		chk("reserved mode", 1, spd_out);
		chk("reserved link ind", 1, lnk_out);
		wb(1'b1, 7'h78, 32'h0000_0000);
		wb(1'b1, 7'h00, 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk("10M unlit", 1, spd_out);
		wb(1'b1, 7'h00, 32'h0000_2000);
		repeat (3) @(posedge clk);
		chk("100M lit", 0, spd_out);
		$display("test indicator modes done");
		wb(1'b1, 7'h40, 32'hFFFF_FFFF);
		wb(1'b0, 7'h40, 32'h0);
		chk("unmapped read", 0, q);
		$display("test unmapped done");
		finish_test();
	end
endmodule

`default_nettype wire
